// ### core/drh_defines.svh
// Offsets, fields, reset values and timing counts of the reference and homing block
// Functional notes
// [R1] Host velocity references are interpolated linearly, with no other choice.
// [R2] Profile selector 1 with loop selector 2 gives host-interpolated velocity operation.
// [R3] Profile selector 0 routes setpoints and commands into the internal generator.
// [R4] Generator builds a time-optimal trajectory within limits, smoothing and override.
// [R5] Generated positions pass the configured interpolation method before use.
// [R6] Velocity and acceleration feed-forward derived and applied every 125 us sample.
// [R7] A positioning command holds target, maximum speed, acceleration and deceleration.
// [R8] Host positions go through the fine interpolator with feed-forward applied.
// [R9] Configured host sample period must equal the host's actual delivery period.
// [R10] Jerk limiting lengthens every acceleration and deceleration phase by smoothing time.
// [R11] Maximum speed reference is scaled by the override percentage.
// [R12] Smoothing time acts only when the profile shape selector holds 3.
// [R13] Method -12 takes stored offset as reference position; absolute position recomputed.
// [R14] Every later method -12 activation redefines the reference at the current position.
// [R15] Method -10 drives clockwise to a block, then reverses to a zero pulse.
// [R16] Method -11 drives anti-clockwise to a block, reverses, stops on first zero pulse.
// [R17] Methods -8 and -9 drive to a block without zero pulse; offset applied.
// [R18] Block search is confined to the configured maximum search distance.
// [R19] No block within range aborts homing, stops motion, raises homing error.
`ifndef DRH_DEFINES_SVH
`define DRH_DEFINES_SVH

`define DRH_TICK_US 125
`define DRH_CLK_MHZ 250
`define DRH_TICK_CYC (`DRH_TICK_US * `DRH_CLK_MHZ)

`define DRH_OFF_CTRL 8'h00
`define DRH_OFF_SMOOTH 8'h04
`define DRH_OFF_OVR 8'h08
`define DRH_OFF_HOSTTS 8'h0c
`define DRH_OFF_RANGE 8'h10
`define DRH_OFF_HOFFS 8'h14
`define DRH_OFF_TARGET 8'h18
`define DRH_OFF_VMAX 8'h1c
`define DRH_OFF_ACC 8'h20
`define DRH_OFF_DEC 8'h24
`define DRH_OFF_HOSTREF 8'h28
`define DRH_OFF_HSPEED 8'h2c
`define DRH_OFF_STATUS 8'h30
`define DRH_OFF_MASK 8'h34
`define DRH_OFF_POS 8'h38
`define DRH_OFF_STATE 8'h3c

`define DRH_CTRL_START_BIT 7
`define DRH_OVR_RST 8'h64
`define DRH_OVR_DIV 64'h0000_0000_0000_0064
`define DRH_SMOOTH_MAX 4'h8
`define DRH_PROF_PG 1'h0
`define DRH_PROF_IP 1'h1
`define DRH_LOOP_VEL 2'h2
`define DRH_SHAPE_JERK 2'h3

`define DRH_HM_M8 8'hf8
`define DRH_HM_M9 8'hf7
`define DRH_HM_M10 8'hf6
`define DRH_HM_M11 8'hf5
`define DRH_HM_M12 8'hf4

`define DRH_ST_HDONE 0
`define DRH_ST_HERR 1
`define DRH_ST_REACHED 2

`define DRH_RESP_OKAY 2'h0
`define DRH_RESP_SLVERR 2'h2

`endif

// ### core/drh_pkg.sv
// Types of the reference and homing block
package drh_pkg;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEARCH = 2'b01,
    H_ZERO = 2'b10
  } drh_home_t;

  typedef struct packed {
    logic [7:0] method;
    logic start;
    logic interp_mid;
    logic [1:0] shape;
    logic [1:0] loop_sel;
    logic prof_sel;
  } drh_ctrl_t;

  typedef struct packed {
    logic [31:0] pos_ref;
    logic [31:0] speed_ref;
    logic [31:0] vel_ff;
    logic [31:0] acc_ff;
  } drh_refs_t;

  typedef struct packed {
    drh_ctrl_t ctrl;
    logic [3:0] smooth;
    logic [7:0] ovr;
    logic [3:0] host_ts;
    logic [31:0] range;
    logic [31:0] hoffs;
    logic [31:0] target;
    logic [31:0] vmax;
    logic [31:0] acc;
    logic [31:0] dec;
    logic [31:0] hspeed;
    logic [31:0] host_ref;
    logic host_new;
    logic [2:0] sts;
    logic [2:0] mask;
    drh_home_t hstate;
    logic hdir_neg;
    logic [31:0] hstart;
    logic [31:0] home_ref;
    logic homed;
    logic [31:0] tick_cnt;
    logic [31:0] gen_pos;
    logic [31:0] gen_vel;
    logic move_active;
    logic [39:0] ma_sum;
    logic [7:0] ma_idx;
    logic [8:0] ma_fill;
    logic [31:0] sm_pos;
    logic [31:0] ip_val;
    logic [31:0] ip_step;
    logic [8:0] ip_cnt;
    drh_refs_t refs;
    logic blk_s1;
    logic blk_s2;
    logic zp_s1;
    logic zp_s2;
    logic zp_s3;
    logic [7:0] awaddr;
    logic aw_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_got;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } drh_state_t;

endpackage

// ### core/drh_ref_homing.sv
// Reference generation, fine interpolation, feed-forward and block-search homing
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "drh_defines.svh"

module drh_ref_homing #(
  parameter int TICK_CYC = `DRH_TICK_CYC
) (
  input wire logic aclk, // 250 MHz clock
  input wire logic aresetn, // Sync reset
  input wire logic ce, // Clock enable
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [31:0] enc_pos, // Encoder position, same clock
  input wire logic block_in, // Mechanical block detect pin
  input wire logic zero_pulse_in, // Encoder zero pulse pin
  output drh_pkg::drh_refs_t refs, // References to the loops
  output logic homed, // Homing completed
  output logic irq // Interrupt, level
);

  drh_pkg::drh_state_t r_q;
  drh_pkg::drh_state_t r_d;
  logic [31:0] ma_mem [0:255];

  logic [4:0] wr_idx;
  logic [4:0] rd_idx;
  logic wr_fire;
  logic rd_fire;
  logic [2:0] ev;
  logic [2:0] rd_clr;
  logic tick;
  logic zp_rise;
  logic pos_mode;
  logic jerk;
  logic up;
  logic [31:0] vlim;
  logic signed [31:0] rem;
  logic signed [31:0] rem1;
  logic signed [31:0] vgoal;
  logic signed [31:0] step;
  logic signed [31:0] v1;
  logic signed [31:0] p1;
  logic signed [31:0] vs;
  logic signed [31:0] old_v;
  logic signed [31:0] pos_out;
  logic signed [31:0] vff;
  logic [63:0] vsq;
  logic [63:0] blim;
  logic [63:0] rem_abs;
  logic [8:0] ma_n;
  logic [3:0] sm_k;
  logic [31:0] hdist;
  logic [31:0] hvel;
  logic ma_we;

  // Word index of a mapped register, 5'h10 for anything else
  function automatic logic [4:0] reg_dec(input logic [7:0] a);
    reg_dec = (a[1:0] == 2'h0 && a[7:6] == 2'h0) ? {1'b0, a[5:2]} : 5'h10;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge[8*i +: 8] = n[8*i +: 8];
      end
    end
  endfunction

  function automatic logic [31:0] sabs(input logic [31:0] x);
    sabs = x[31] ? 32'(-$signed(x)) : x;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_d = r_q;
    ev = 3'h0;
    rd_clr = 3'h0;
    ma_we = 1'b0;
    vff = 32'sh0000_0000;
    r_d.ctrl.start = 1'b0;

    r_d.blk_s1 = block_in;
    r_d.blk_s2 = r_q.blk_s1;
    r_d.zp_s1 = zero_pulse_in;
    r_d.zp_s2 = r_q.zp_s1;
    r_d.zp_s3 = r_q.zp_s2;
    zp_rise = r_q.zp_s2 & ~r_q.zp_s3;

    // Register bus
    wr_idx = reg_dec(r_q.awaddr);
    rd_idx = reg_dec(s_axi_araddr);
    if (r_q.awready && s_axi_awvalid) begin
      r_d.aw_got = 1'b1;
      r_d.awaddr = s_axi_awaddr;
    end
    if (r_q.wready && s_axi_wvalid) begin
      r_d.w_got = 1'b1;
      r_d.wdata = s_axi_wdata;
      r_d.wstrb = s_axi_wstrb;
    end
    if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
    end
    wr_fire = r_q.aw_got && r_q.w_got && !r_q.bvalid;
    if (wr_fire) begin
      r_d.aw_got = 1'b0;
      r_d.w_got = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = `DRH_RESP_OKAY;
      unique case (r_q.awaddr)
        `DRH_OFF_CTRL: r_d.ctrl = 15'(merge(32'(r_q.ctrl), r_q.wdata, r_q.wstrb));
        `DRH_OFF_SMOOTH: r_d.smooth = 4'(merge(32'(r_q.smooth), r_q.wdata, r_q.wstrb));
        `DRH_OFF_OVR: r_d.ovr = 8'(merge(32'(r_q.ovr), r_q.wdata, r_q.wstrb));
        `DRH_OFF_HOSTTS: r_d.host_ts = 4'(merge(32'(r_q.host_ts), r_q.wdata, r_q.wstrb));
        `DRH_OFF_RANGE: r_d.range = merge(r_q.range, r_q.wdata, r_q.wstrb);
        `DRH_OFF_HOFFS: r_d.hoffs = merge(r_q.hoffs, r_q.wdata, r_q.wstrb);
        `DRH_OFF_TARGET: begin
          r_d.target = merge(r_q.target, r_q.wdata, r_q.wstrb); // R7
          r_d.move_active = 1'b1;
        end
        `DRH_OFF_VMAX: r_d.vmax = merge(r_q.vmax, r_q.wdata, r_q.wstrb);
        `DRH_OFF_ACC: r_d.acc = merge(r_q.acc, r_q.wdata, r_q.wstrb);
        `DRH_OFF_DEC: r_d.dec = merge(r_q.dec, r_q.wdata, r_q.wstrb);
        `DRH_OFF_HOSTREF: begin
          r_d.host_ref = merge(r_q.host_ref, r_q.wdata, r_q.wstrb);
          r_d.host_new = 1'b1;
        end
        `DRH_OFF_HSPEED: r_d.hspeed = merge(r_q.hspeed, r_q.wdata, r_q.wstrb);
        `DRH_OFF_MASK: r_d.mask = 3'(merge(32'(r_q.mask), r_q.wdata, r_q.wstrb));
        `DRH_OFF_STATUS, `DRH_OFF_POS, `DRH_OFF_STATE: r_d.bresp = `DRH_RESP_OKAY;
        default: r_d.bresp = `DRH_RESP_SLVERR;
      endcase
      if (wr_idx == 5'h10) begin
        r_d.bresp = `DRH_RESP_SLVERR;
      end
    end

    if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
    end
    rd_fire = r_q.arready && s_axi_arvalid;
    if (rd_fire) begin
      r_d.rvalid = 1'b1;
      r_d.rresp = (rd_idx == 5'h10) ? `DRH_RESP_SLVERR : `DRH_RESP_OKAY;
      unique case (s_axi_araddr)
        `DRH_OFF_CTRL: r_d.rdata = 32'(r_q.ctrl);
        `DRH_OFF_SMOOTH: r_d.rdata = 32'(r_q.smooth);
        `DRH_OFF_OVR: r_d.rdata = 32'(r_q.ovr);
        `DRH_OFF_HOSTTS: r_d.rdata = 32'(r_q.host_ts);
        `DRH_OFF_RANGE: r_d.rdata = r_q.range;
        `DRH_OFF_HOFFS: r_d.rdata = r_q.hoffs;
        `DRH_OFF_TARGET: r_d.rdata = r_q.target;
        `DRH_OFF_VMAX: r_d.rdata = r_q.vmax;
        `DRH_OFF_ACC: r_d.rdata = r_q.acc;
        `DRH_OFF_DEC: r_d.rdata = r_q.dec;
        `DRH_OFF_HOSTREF: r_d.rdata = r_q.host_ref;
        `DRH_OFF_HSPEED: r_d.rdata = r_q.hspeed;
        `DRH_OFF_STATUS: begin
          r_d.rdata = 32'(r_q.sts);
          rd_clr = r_q.sts;
        end
        `DRH_OFF_MASK: r_d.rdata = 32'(r_q.mask);
        `DRH_OFF_POS: r_d.rdata = enc_pos + r_q.home_ref; // R13
        `DRH_OFF_STATE: r_d.rdata = {26'h000_0000, r_q.move_active, r_q.homed, r_q.hstate, 1'b0, r_q.host_new};
        default: r_d.rdata = 32'h0000_0000;
      endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Position-controller sample tick
    tick = (r_q.tick_cnt == 32'(TICK_CYC - 1));
    r_d.tick_cnt = tick ? 32'h0000_0000 : r_q.tick_cnt + 32'h0000_0001;

    pos_mode = (r_q.ctrl.loop_sel != `DRH_LOOP_VEL);
    jerk = (r_q.ctrl.shape == `DRH_SHAPE_JERK); // R12
    vlim = 32'((64'(r_q.vmax) * 64'(r_q.ovr)) / `DRH_OVR_DIV); // R11
    rem = $signed(r_q.target - r_q.gen_pos);
    rem_abs = 64'(sabs(rem));
    vsq = 64'($signed(r_q.gen_vel) * $signed(r_q.gen_vel));
    blim = (rem_abs * 64'(r_q.dec)) << 1;

    // Time-optimal goal: full speed until braking distance is reached
    if (pos_mode) begin
      if (!r_q.move_active || vsq >= blim) begin
        vgoal = 32'sh0000_0000;
      end else begin
        vgoal = rem[31] ? -$signed(vlim) : $signed(vlim); // R4
      end
    end else if ($signed(r_q.target) > $signed(vlim)) begin
      vgoal = $signed(vlim);
    end else if ($signed(r_q.target) < -$signed(vlim)) begin
      vgoal = -$signed(vlim);
    end else begin
      vgoal = $signed(r_q.target);
    end
    up = ($signed(vgoal) > $signed(r_q.gen_vel)) ? !r_q.gen_vel[31] : ($signed(r_q.gen_vel) <= 0);
    step = up ? $signed(r_q.acc) : $signed(r_q.dec);
    if ($signed(r_q.gen_vel) < vgoal) begin
      v1 = ($signed(r_q.gen_vel) + step > vgoal) ? vgoal : $signed(r_q.gen_vel) + step;
    end else if ($signed(r_q.gen_vel) > vgoal) begin
      v1 = ($signed(r_q.gen_vel) - step < vgoal) ? vgoal : $signed(r_q.gen_vel) - step;
    end else begin
      v1 = vgoal;
    end
    p1 = pos_mode ? $signed(r_q.gen_pos) + v1 : $signed(r_q.gen_pos);
    rem1 = $signed(r_q.target) - p1;
    if (pos_mode && r_q.move_active && (rem1 == 0 || rem1[31] != rem[31] || rem == 0)) begin
      p1 = $signed(r_q.target);
      v1 = 32'sh0000_0000;
    end

    // Moving average over 2^k samples adds 2^k-sample length to each ramp
    sm_k = (r_q.smooth > `DRH_SMOOTH_MAX) ? `DRH_SMOOTH_MAX : r_q.smooth;
    ma_n = 9'h001 << sm_k;
    old_v = (r_q.ma_fill >= ma_n) ? $signed(ma_mem[r_q.ma_idx]) : 32'sh0000_0000;
    vs = jerk ? 32'(($signed(r_q.ma_sum) + 40'(v1) - 40'(old_v)) >>> sm_k) : v1; // R10

    if (tick) begin
      // Interpolator for host references, linear only
      if (r_q.host_new) begin
        r_d.host_new = 1'b0;
        r_d.ip_step = 32'(($signed(r_q.host_ref) - $signed(r_q.ip_val)) >>> r_q.host_ts); // R1 R9
        r_d.ip_cnt = 9'h001 << ((r_q.host_ts > `DRH_SMOOTH_MAX) ? `DRH_SMOOTH_MAX : r_q.host_ts);
        r_d.ip_val = (r_q.host_ts == 4'h0) ? r_q.host_ref : r_q.ip_val;
      end else if (r_q.ip_cnt != 9'h000) begin
        r_d.ip_cnt = r_q.ip_cnt - 9'h001;
        r_d.ip_val = (r_q.ip_cnt == 9'h001) ? r_q.host_ref : r_q.ip_val + r_q.ip_step;
      end

      if (r_q.ctrl.prof_sel == `DRH_PROF_PG) begin // R3
        r_d.gen_vel = v1;
        r_d.gen_pos = p1;
        if (pos_mode && r_q.move_active && p1 == $signed(r_q.target) && v1 == 0) begin
          r_d.move_active = 1'b0;
          ev[`DRH_ST_REACHED] = 1'b1;
        end
        if (jerk) begin
          ma_we = 1'b1;
          r_d.ma_sum = $signed(r_q.ma_sum) + 40'(v1) - 40'(old_v);
          r_d.ma_idx = 8'((9'(r_q.ma_idx) + 9'h001) & (ma_n - 9'h001));
          r_d.ma_fill = (r_q.ma_fill >= ma_n) ? r_q.ma_fill : r_q.ma_fill + 9'h001;
        end
        r_d.sm_pos = pos_mode ? 32'($signed(r_q.sm_pos) + vs) : r_q.sm_pos;
        // Interpolation method: direct, or midpoint of two samples
        pos_out = r_q.ctrl.interp_mid ? 32'((33'($signed(r_d.sm_pos)) + 33'($signed(r_q.sm_pos))) >>> 1)
          : $signed(r_d.sm_pos); // R5
      end else begin
        pos_out = $signed(r_d.ip_val); // R8
      end

      if (pos_mode) begin
        vff = pos_out - $signed(r_q.refs.pos_ref); // R6
        r_d.refs.pos_ref = pos_out;
        r_d.refs.vel_ff = vff;
        r_d.refs.acc_ff = vff - $signed(r_q.refs.vel_ff); // R6
        r_d.refs.speed_ref = vff;
      end else begin
        r_d.refs.speed_ref = (r_q.ctrl.prof_sel == `DRH_PROF_IP) ? r_d.ip_val : vs; // R2
        r_d.refs.vel_ff = 32'h0000_0000;
        r_d.refs.acc_ff = 32'h0000_0000;
      end
    end else begin
      pos_out = $signed(r_q.refs.pos_ref);
    end

    ////////////////////////////////////////////////////////////////////
    // Homing
    hdist = sabs(enc_pos - r_q.hstart);
    hvel = r_q.hdir_neg ? 32'(-$signed(r_q.hspeed)) : r_q.hspeed;
    unique case (r_q.hstate)
      drh_pkg::H_IDLE: begin
        if (r_q.ctrl.start) begin
          r_d.hstart = enc_pos;
          r_d.hdir_neg = (r_q.ctrl.method == `DRH_HM_M9) || (r_q.ctrl.method == `DRH_HM_M11);
          unique case (r_q.ctrl.method)
            `DRH_HM_M12: begin
              r_d.home_ref = r_q.hoffs - enc_pos; // R13 R14
              r_d.homed = 1'b1;
              ev[`DRH_ST_HDONE] = 1'b1;
            end
            `DRH_HM_M8, `DRH_HM_M9, `DRH_HM_M10, `DRH_HM_M11: begin
              r_d.hstate = drh_pkg::H_SEARCH; // R15 R16 R17
              r_d.homed = 1'b0;
            end
            default: ev[`DRH_ST_HERR] = 1'b1;
          endcase
        end
      end
      drh_pkg::H_SEARCH: begin
        r_d.refs.speed_ref = hvel;
        if (r_q.blk_s2) begin
          if (r_q.ctrl.method == `DRH_HM_M10 || r_q.ctrl.method == `DRH_HM_M11) begin
            r_d.hstate = drh_pkg::H_ZERO; // R15 R16
            r_d.hdir_neg = !r_q.hdir_neg;
          end else begin
            r_d.home_ref = r_q.hoffs - enc_pos; // R17
            r_d.homed = 1'b1;
            r_d.hstate = drh_pkg::H_IDLE;
            r_d.refs.speed_ref = 32'h0000_0000;
            ev[`DRH_ST_HDONE] = 1'b1;
          end
        end else if (hdist > r_q.range) begin
          r_d.hstate = drh_pkg::H_IDLE; // R18 R19
          r_d.refs.speed_ref = 32'h0000_0000;
          ev[`DRH_ST_HERR] = 1'b1;
        end
      end
      drh_pkg::H_ZERO: begin
        r_d.refs.speed_ref = hvel;
        if (zp_rise) begin
          r_d.home_ref = r_q.hoffs - enc_pos; // R15 R16
          r_d.homed = 1'b1;
          r_d.hstate = drh_pkg::H_IDLE;
          r_d.refs.speed_ref = 32'h0000_0000;
          ev[`DRH_ST_HDONE] = 1'b1;
        end else if (hdist > r_q.range) begin
          r_d.hstate = drh_pkg::H_IDLE; // R18 R19
          r_d.refs.speed_ref = 32'h0000_0000;
          ev[`DRH_ST_HERR] = 1'b1;
        end
      end
    endcase

    // Event set wins over read clear
    r_d.sts = (r_q.sts & ~rd_clr) | ev;
    r_d.irq = |(r_d.sts & r_d.mask);
    r_d.awready = !r_d.aw_got && !r_d.bvalid;
    r_d.wready = !r_d.w_got && !r_d.bvalid;
    r_d.arready = !r_d.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q <= '0;
      r_q.ovr <= `DRH_OVR_RST;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  // Smoothing history; unfilled slots are masked by the fill count
  always_ff @(posedge aclk) begin
    if (ce && ma_we) begin
      ma_mem[r_q.ma_idx] <= v1;
    end
  end

  assign s_axi_awready = r_q.awready;
  assign s_axi_wready = r_q.wready;
  assign s_axi_bvalid = r_q.bvalid;
  assign s_axi_bresp = r_q.bresp;
  assign s_axi_arready = r_q.arready;
  assign s_axi_rvalid = r_q.rvalid;
  assign s_axi_rdata = r_q.rdata;
  assign s_axi_rresp = r_q.rresp;
  assign refs = r_q.refs;
  assign homed = r_q.homed;
  assign irq = r_q.irq;

endmodule
`default_nettype wire

// ### tb/drh_axis_model.sv
// Axis model: integrates the speed demand, end stops and index mark
`timescale 1ns/1ns
`default_nettype none
module drh_axis_model (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset
  input wire drh_pkg::drh_refs_t refs, // Speed demand
  output logic [31:0] enc_pos, // Axis position
  output logic block_in, // At end stop
  output logic zero_pulse_in // Index mark
);
  localparam int STOP = 200;
  // Nonzero start exposes the home offset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enc_pos <= 32'h7;
    end else begin
      enc_pos <= enc_pos + refs.speed_ref;
    end
  end
  assign zero_pulse_in = enc_pos[4];
  assign block_in = $signed(enc_pos) >= STOP || $signed(enc_pos) <= -STOP;
endmodule
`default_nettype wire

// ### tb/drh_ref_homing_asserts.sv
// Port-level assertions for the reference and homing block
`timescale 1ns/1ns
`default_nettype none
module drh_ref_homing_asserts (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset
  input wire logic ce, // Clock enable
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B resp
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire drh_pkg::drh_refs_t refs, // Loop references
  input wire logic homed, // Homing done
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready && ce;
  endsequence
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata dropped");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write while busy");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read while busy");
  a_wresp_time: assert property (wr_taken ##1 ce |=> s_axi_bvalid)
    else $error("bvalid late");
  a_rresp_time: assert property (rd_taken |=> s_axi_rvalid)
    else $error("rvalid late");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn && ce |=>
    !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready && !homed && !irq)
    else $error("active in reset");
  // Position and feed-forward refs move on sample ticks only
  a_ref_tick: assert property ($changed({refs.pos_ref, refs.vel_ff, refs.acc_ff}) |=>
    $stable({refs.pos_ref, refs.vel_ff, refs.acc_ff})[*3])
    else $error("refs off tick");
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the reference and homing block
`timescale 1ns/1ns
`default_nettype none
`include "drh_defines.svh"
module testbench;
  localparam int TICK = 8;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } drh_row_t;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, enc_pos;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic block_in, zero_pulse_in, homed, irq, rev;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  drh_pkg::drh_refs_t refs;
  int n_fail = 0, comparisons = 0, n;
  logic [7:0] hm [5] = '{`DRH_HM_M8, `DRH_HM_M9, `DRH_HM_M10, `DRH_HM_M11, `DRH_HM_M8};
  drh_row_t rows [9] = '{
    '{1'b0, `DRH_OFF_OVR, 32'h0, 32'h64, 2'h0},
    '{1'b1, `DRH_OFF_SMOOTH, 32'h9, 32'h9, 2'h0},
    '{1'b1, `DRH_OFF_HOSTTS, 32'h2, 32'h2, 2'h0},
    '{1'b1, `DRH_OFF_RANGE, 32'h1388, 32'h1388, 2'h0},
    '{1'b1, `DRH_OFF_MASK, 32'h7, 32'h7, 2'h0},
    '{1'b1, `DRH_OFF_STATUS, 32'h7, 32'h0, 2'h0},
    '{1'b1, `DRH_OFF_CTRL, 32'h1f, 32'h1f, 2'h0},
    '{1'b1, 8'h40, 32'h5, 32'h0, 2'h2},
    '{1'b1, 8'h02, 32'h5, 32'h0, 2'h2}};
  drh_ref_homing #(.TICK_CYC(TICK)) dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .enc_pos, .block_in, .zero_pulse_in, .refs, .homed, .irq);
  drh_axis_model axis (.aclk, .aresetn, .refs, .enc_pos, .block_in, .zero_pulse_in);
  initial forever #2 aclk = ~aclk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset;
    aresetn <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw = 0, w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    resp = s_axi_rresp;
    check(nm, s_axi_rdata, e);
    s_axi_rready <= 0;
  endtask
  task automatic wait_spd;
    logic [31:0] old;
    old = refs.speed_ref;
    n = 0;
    while (refs.speed_ref === old && n < 200) begin
      @(posedge aclk);
      n++;
    end
  endtask
  initial begin
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
        check("bresp", resp, rows[i].r);
      end
      chk_reg("rdata", rows[i].a, rows[i].e);
      check("rresp", resp, rows[i].r);
    end
    $display("test registers done");
    do_reset();
    wr(`DRH_OFF_HOSTTS, 32'h2);
    wr(`DRH_OFF_CTRL, 32'h5);
    wr(`DRH_OFF_HOSTREF, 32'h28);
    for (int k = 1; k < 5; k++) begin
      wait_spd();
      check("ip step", refs.speed_ref, 10 * k);
    end
    repeat (6 * TICK) @(posedge aclk);
    check("ip hold", refs.speed_ref, 32'h28);
    $display("test host done");
    // Shape 3 stretches the ramp, shape 0 not
    for (int j = 0; j < 2; j++) begin
      do_reset();
      wr(`DRH_OFF_SMOOTH, 32'h3);
      wr(`DRH_OFF_CTRL, j ? 32'h1c : 32'h4);
      wr(`DRH_OFF_VMAX, 32'h28);
      wr(`DRH_OFF_ACC, 32'ha);
      wr(`DRH_OFF_DEC, 32'ha);
      wr(`DRH_OFF_OVR, 32'h32);
      wr(`DRH_OFF_TARGET, 32'h3e8);
      repeat (3 * TICK + 2) @(posedge aclk);
      check("pg early", refs.speed_ref == 32'h14, j == 0);
      repeat (20 * TICK) @(posedge aclk);
      check("pg final", refs.speed_ref, 32'h14);
    end
    $display("test gen done");
    // Pass 5 must hit the range limit
    foreach (hm[i]) begin
      do_reset();
      wr(`DRH_OFF_HSPEED, 32'h5);
      wr(`DRH_OFF_RANGE, i > 3 ? 32'h1e : 32'h3e8);
      wr(`DRH_OFF_CTRL, {17'h0, hm[i], 7'h40});
      repeat (6) @(posedge aclk);
      check("home dir", refs.speed_ref, 32'(i % 2 ? -5 : 5));
      rev = 0;
      n = 0;
      while (homed !== 1'b1 && n < 400) begin
        @(posedge aclk);
        if (refs.speed_ref === 32'(i % 2 ? 5 : -5))
          rev = 1;
        n++;
      end
      check("home rev", rev, i / 2 == 1);
      check("home stop", refs.speed_ref, 32'h0);
      check("homed", homed, i < 4);
      chk_reg("home sts", `DRH_OFF_STATUS, i > 3 ? 32'h2 : 32'h1);
    end
    $display("test block done");
    do_reset();
    wr(`DRH_OFF_MASK, 32'h1);
    wr(`DRH_OFF_HOFFS, 32'h3e8);
    wr(`DRH_OFF_CTRL, {17'h0, `DRH_HM_M12, 7'h40});
    repeat (3) @(posedge aclk);
    check("m12 homed", homed, 1'b1);
    check("irq set", irq, 1'b1);
    chk_reg("m12 pos", `DRH_OFF_POS, 32'h3e8);
    chk_reg("sts clear", `DRH_OFF_STATUS, 32'h1);
    repeat (2) @(posedge aclk);
    check("irq clear", irq, 1'b0);
    wr(`DRH_OFF_MASK, 32'h0);
    wr(`DRH_OFF_HOFFS, 32'h1f4);
    wr(`DRH_OFF_CTRL, {17'h0, `DRH_HM_M12, 7'h40});
    repeat (3) @(posedge aclk);
    check("irq masked", irq, 1'b0);
    chk_reg("m12 again", `DRH_OFF_POS, 32'h1f4);
    wr(`DRH_OFF_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    check("irq unmask", irq, 1'b1);
    $display("test offset done");
    conclude();
  end
  // Whole run is under two thousand clocks
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    conclude();
  end
endmodule
bind drh_ref_homing drh_ref_homing_asserts chk (.aclk, .aresetn, .ce, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .refs, .homed, .irq);
`default_nettype wire
